// >>> sar_adc_sequencer_test.sv
`timescale 1ns/1ns
`include "sarseq_regs.vh"
module sar_adc_sequencer_test;
  reg          clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [5:0]   wb_adr_i;
  reg  [3:0]   wb_sel_i;
  reg  [31:0]  wb_dat_i;
  wire [31:0]  wb_dat_o;
  wire         wb_ack_o, compBit, sampleHold, conv_done_irq;
  reg          timer_trigger_event, ext_trigger_pin;
  reg  [15:0]  analogPinLevel, routeSeen;
  wire [15:0]  channelRoute;
  wire [9:0]   dacCode;
  reg  [159:0] chanLevel;
  reg  [63:0]  expNotes[$];
  reg  [63:0]  note;
  reg  [9:0]   level;
  reg  [7:0]   thresh, hi;
  integer      n_mismatch = 0, comparisons = 0, cycles = 0, seed = 32'hB2D9, k, ch;
  sarseq_adc_ctrl sarseq_adc_ctrl_inst (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_trigger_event,
    .ext_trigger_pin, .compBit, .analogPinLevel, .channelRoute, .sampleHold, .dacCode,
    .conv_done_irq);
  sarseq_afe_model sarseq_afe_model_inst (.clk_sys, .chanLevel, .channelRoute, .sampleHold,
    .dacCode, .compBit);
  // 250 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task final_report;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input [31:0] m);
  begin
    comparisons = comparisons + 1;
    if ((got & m) !== (exp & m))
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // one classic cycle, entered just after an edge; reads leave a note for the watcher
  task wb(input w, input [5:0] a, input [31:0] d, input [31:0] m);
    integer t;
  begin
    if (!w)
      expNotes.push_back({m, d});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= w ? d : $random(seed);
    t = 0;
    do
    begin
      @(posedge clk_sys);
      t = t + 1;
    end while (wb_ack_o !== 1'b1 && t < 50);
    chk(wb_ack_o, 1, 1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  end
  endtask
  task waitIrq(input e, input integer lim);
    integer t;
  begin
    t = 0;
    while (conv_done_irq !== e && t < lim)
    begin
      @(posedge clk_sys);
      t = t + 1;
    end
    chk(conv_done_irq, e, 1);
  end
  endtask
  // read data is taken at the ack edge and matched with the oldest note
  always @(posedge clk_sys)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
    begin
      note = expNotes.pop_front();
      chk(wb_dat_o, note[31:0], note[63:32]);
    end
  // hang guard, about ten times the expected run length
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
  initial
  begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, timer_trigger_event, ext_trigger_pin} = 6'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i, analogPinLevel} = 58'h0;
    chanLevel = {5{$random(seed)}};
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    wb_sel_i <= 4'hF;
    wb(0, `SARSEQ_OFF_MODE, 0, 32'h7FF);
    wb(0, `SARSEQ_OFF_STATUS, 0, 3);
    wb(1, 6'h3C, 32'hFFFFFFFF, 0);
    wb(0, 6'h3C, 0, 32'hFFFFFFFF);
    wb(1, `SARSEQ_OFF_MODE, 32'h40E, 0);
    wb(0, `SARSEQ_OFF_MODE, 32'h40E, 32'h7FF);
    wb(1, `SARSEQ_OFF_MASK, 1, 0);
    // select mode, software start, full-scale and zero first
    for (k = 0; k < 4; k = k + 1)
    begin
      ch = $random(seed) & 15;
      level = (k == 0) ? 10'h3FF : (k == 1) ? 10'h000 : $random(seed);
      chanLevel[ch*10 +: 10] = level;
      wb(1, `SARSEQ_OFF_CHSEL, ch, 0);
      wb(1, `SARSEQ_OFF_MODE, 32'h80, 0);
      waitIrq(1, 300);
      wb(1, `SARSEQ_OFF_STATUS, 1, 0);
      waitIrq(0, 10);
      waitIrq(1, 300);
      wb(1, `SARSEQ_OFF_MODE, 0, 0);
      wb(1, `SARSEQ_OFF_MASK, 0, 0);
      waitIrq(0, 10);
      wb(1, `SARSEQ_OFF_MASK, 1, 0);
      wb(0, `SARSEQ_OFF_RESULT, {level, 6'h00}, 32'hFFFF);
      wb(0, `SARSEQ_OFF_RESHIGH, level[9:2], 32'hFF);
      wb(1, `SARSEQ_OFF_STATUS, 1, 0);
      waitIrq(0, 10);
      repeat (60) @(posedge clk_sys);
      chk(conv_done_irq, 0, 1);
    end
    // threshold compare, both conditions at the boundary
    for (k = 0; k < 4; k = k + 1)
    begin
      thresh = 8'h02 + ($random(seed) & 8'hFC);
      hi = k[1] ? thresh : thresh - 8'h01;
      chanLevel[ch*10 +: 10] = {hi, k[1:0]};
      wb(1, `SARSEQ_OFF_PFTHR, thresh, 0);
      wb(1, `SARSEQ_OFF_PFMODE, 32'h2 | k[0], 0);
      wb(1, `SARSEQ_OFF_MODE, 32'h80, 0);
      repeat (150) @(posedge clk_sys);
      chk(conv_done_irq, k[0] ^ k[1], 1);
      wb(1, `SARSEQ_OFF_MODE, 0, 0);
      wb(0, `SARSEQ_OFF_RESHIGH, hi, 32'hFF);
      wb(1, `SARSEQ_OFF_STATUS, 1, 0);
    end
    wb(1, `SARSEQ_OFF_PFMODE, 0, 0);
    // timer then rising external edge; nothing may start before it
    for (k = 1; k < 3; k = k + 1)
    begin
      wb(1, `SARSEQ_OFF_MODE, 32'h80 | (k << 8) | ((k - 1) << 10), 0);
      repeat (60) @(posedge clk_sys);
      chk(conv_done_irq, 0, 1);
      timer_trigger_event <= (k == 1);
      ext_trigger_pin <= (k == 2);
      @(posedge clk_sys);
      timer_trigger_event <= 1'b0;
      waitIrq(1, 200);
      wb(1, `SARSEQ_OFF_MODE, 0, 0);
      ext_trigger_pin <= 1'b0;
      wb(1, `SARSEQ_OFF_STATUS, 1, 0);
    end
    // high speed: identical rewrite mid-conversion restarts it
    wb(1, `SARSEQ_OFF_MODE, 32'h90, 0);
    repeat (12) @(posedge clk_sys);
    wb(1, `SARSEQ_OFF_MODE, 32'h90, 0);
    // restart moves the end to a whole conversion after the rewrite
    repeat (15) @(posedge clk_sys);
    chk(conv_done_irq, 0, 1);
    waitIrq(1, 200);
    wb(1, `SARSEQ_OFF_MODE, 0, 0);
    wb(0, `SARSEQ_OFF_RESHIGH, hi, 32'hFF);
    wb(1, `SARSEQ_OFF_STATUS, 1, 0);
    // scan over channels 0 and 1
    wb(1, `SARSEQ_OFF_CHSEL, 1, 0);
    wb(1, `SARSEQ_OFF_MODE, 32'hC0, 0);
    routeSeen = 16'h0000;
    repeat (300)
    begin
      @(posedge clk_sys);
      routeSeen = routeSeen | channelRoute;
    end
    chk(routeSeen, 3, 32'hFFFF);
    wb(1, `SARSEQ_OFF_MODE, 0, 0);
    // unselected pins read as digital inputs
    analogPinLevel <= $random(seed);
    wb(1, `SARSEQ_OFF_CHSEL, ch, 0);
    wb(0, `SARSEQ_OFF_PORTIN, analogPinLevel, 32'hFFFF & ~(1 << ch));
    repeat (3) @(posedge clk_sys);
    chk(expNotes.size(), 0, 32'hFF);
    final_report;
  end
endmodule

// >>> sarseq_adc_ctrl.v
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - sixteen inputs, exactly one routed to sample-hold per conversion
// - successive approximation produces a ten-bit result
// - start by software, timer event, or external pin edge
// - scan bit zero converts one channel, one steps channels
// - conversions repeat; interrupt after each completed conversion
// - power-fail enabled: interrupt only when byte compare condition holds
// - one bit resolved per step, msb first down to lsb
// - after lsb the approximation value moves to the result register
// - approximation register has no software address
// - result left-justified in sixteen bits, low six bits zero
// - byte view returns only the upper eight result bits
// - unselected analog pins remain readable as digital inputs
// - sample-hold kept in hold for the whole conversion
// - threshold register and power-fail mode register set by software
// - mode register sets conversion time and starts or stops
// - enable bit zero stops conversion, one enables it
// - high speed: rewriting mode register with the same value mid-conversion restarts it
module sarseq_adc_ctrl
(
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // triggers
  input  wire        timer_trigger_event,
  input  wire        ext_trigger_pin,
  // analog front end
  input  wire        compBit,
  input  wire [15:0] analogPinLevel,
  output reg  [15:0] channelRoute,
  output reg         sampleHold,
  output reg  [9:0]  dacCode,
  // interrupt
  output reg         conv_done_irq
);
`include "sarseq_regs.vh"

  // one-hot sequencer states
  localparam [3:0] ST_IDLE   = 4'b0001;
  localparam [3:0] ST_SAMPLE = 4'b0010;
  localparam [3:0] ST_CONV   = 4'b0100;
  localparam [3:0] ST_WAIT   = 4'b1000;

  // registers
  reg  [10:0] conv_mode_reg;
  reg  [3:0]  channel_select_reg;
  reg  [1:0]  pf_mode_reg;
  reg  [7:0]  pf_threshold_reg;
  reg  [9:0]  resultBits_reg;
  reg  [1:0]  status_reg;
  reg  [1:0]  mask_reg;
  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg  [9:0]  approx_reg;
  reg  [9:0]  trialMask_reg;
  reg  [3:0]  activeCh_reg;
  reg  [3:0]  activeCh_next;
  reg         extPrev_reg;
  reg  [15:0] portIn_reg;

  // decoded controls and datapath nets
  wire        accessNow;
  wire        wrNow;
  wire        stepPulse;
  wire        conv_enable_bit;
  wire        scan_select_bit;
  wire [1:0]  hsSel;
  wire        highSpeed;
  wire [1:0]  trgSel;
  wire        extEdge;
  reg         trigHit;
  wire        restartNow;
  wire        lastStep;
  wire [9:0]  finalCode;
  wire        pfMatch;
  wire        doneEvent;
  wire        doneClear;
  wire        doneNext;
  wire [15:0] leftResult;
  wire [31:0] modeMerged;
  wire [10:0] modeWrite;

  // one-hot decode used for routing and port masking
  function [15:0] chanOneHot;
    input [3:0] ch;
    begin
      chanOneHot = 16'h0001 << ch;
    end
  endfunction

  // byte-lane merge for word writes
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0]  sel;
    integer i;
    begin
      laneMerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          laneMerge[i*8 +: 8] = wdat[i*8 +: 8];
    end
  endfunction

  // writes land in the cycle the request is taken; ack follows one cycle later
  sarseq_wb_slave uBus
  (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_ack_o  (wb_ack_o),
    .accessNow (accessNow)
  );

  // mode register fields
  assign wrNow           = accessNow & wb_we_i;
  assign conv_enable_bit = conv_mode_reg[`SARSEQ_MODE_EN];
  assign scan_select_bit = conv_mode_reg[`SARSEQ_MODE_SCAN];
  assign hsSel           = conv_mode_reg[`SARSEQ_MODE_HS_HI:`SARSEQ_MODE_HS_LO];
  assign highSpeed       = |hsSel;
  assign trgSel          = conv_mode_reg[`SARSEQ_MODE_TRG_HI:`SARSEQ_MODE_TRG_LO];
  // lanes merged first, then cut to the register width
  assign modeMerged      = laneMerge({21'h0, conv_mode_reg}, wb_dat_i, wb_sel_i);
  assign modeWrite       = modeMerged[`SARSEQ_MODE_W-1:0];

  // step rate from the frequency code: conversion time selection
  sarseq_step_timer uStep
  (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .run       (state_reg != ST_IDLE && state_reg != ST_WAIT && !restartNow),
    .frCode    (conv_mode_reg[`SARSEQ_MODE_FR_HI:`SARSEQ_MODE_FR_LO]),
    .highSpeed (highSpeed),
    .stepPulse (stepPulse)
  );

  // trigger select; external edge polarity chosen by a mode bit
  assign extEdge = conv_mode_reg[`SARSEQ_MODE_EDGE] ? (ext_trigger_pin & ~extPrev_reg)
                                                    : (~ext_trigger_pin & extPrev_reg);

  // start source; software start stays armed, so it repeats on its own
  always @*
  begin
    case (trgSel)
      `SARSEQ_TRG_SW:    trigHit = 1'b1;
      `SARSEQ_TRG_TIMER: trigHit = timer_trigger_event;
      `SARSEQ_TRG_EXT:   trigHit = extEdge;
      default:           trigHit = 1'b0;
    endcase
  end

  // same-value rewrite of the mode register in high speed restarts
  // only while busy: a waiting sequencer must not start without its trigger
  // normal-mode rewrites mid-conversion are not guarded; software avoids them
  assign restartNow = wrNow && wb_adr_i == `SARSEQ_OFF_MODE && highSpeed
                      && (state_reg == ST_SAMPLE || state_reg == ST_CONV)
                      && modeWrite == conv_mode_reg;

  assign lastStep   = trialMask_reg[0];
  assign finalCode  = compBit ? approx_reg : (approx_reg & ~trialMask_reg);
  // upper byte of the new result against the threshold, same cycle as write
  assign pfMatch    = pf_mode_reg[`SARSEQ_PF_BELOW] ? (finalCode[9:2] <  pf_threshold_reg)
                                                    : (finalCode[9:2] >= pf_threshold_reg);
  assign doneEvent  = state_reg == ST_CONV && stepPulse && lastStep && !restartNow
                      && (!pf_mode_reg[`SARSEQ_PF_EN] || pfMatch);
  assign leftResult = {resultBits_reg, 6'h00};

  // write-one clear of done; a conversion end in the same cycle wins
  assign doneClear  = wrNow && wb_adr_i == `SARSEQ_OFF_STATUS && wb_sel_i[0]
                      && wb_dat_i[`SARSEQ_ST_DONE];
  assign doneNext   = doneEvent | (status_reg[`SARSEQ_ST_DONE] & ~doneClear);

  // next-state logic
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (conv_enable_bit && trigHit)
          state_next = ST_SAMPLE;
      ST_SAMPLE:
        if (stepPulse)
          state_next = ST_CONV;
      ST_CONV:
        if (stepPulse && lastStep)
          state_next = (trgSel == `SARSEQ_TRG_SW) ? ST_SAMPLE : ST_WAIT;
      ST_WAIT:
        if (trigHit)
          state_next = ST_SAMPLE;
      default:
        state_next = ST_IDLE;
    endcase
    // disable and a restart override whatever the case chose
    if (!conv_enable_bit)
      state_next = ST_IDLE;
    else if (restartNow)
      state_next = ST_SAMPLE;
  end

  // channel of the coming sample; the route flop follows it on the same edge
  always @*
  begin
    activeCh_next = activeCh_reg;
    if (state_next == ST_SAMPLE && state_reg != ST_SAMPLE)
    begin
      // first conversion takes channel 0 when scanning, else the chosen channel; scan advances after
      if (state_reg == ST_IDLE || !scan_select_bit || restartNow)
        activeCh_next = scan_select_bit ? 4'h0 : channel_select_reg;
      else if (activeCh_reg == channel_select_reg)
        activeCh_next = 4'h0;
      else
        activeCh_next = activeCh_reg + 4'h1;
    end
  end

  // sequencer datapath: approximation register is internal only
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg      <= ST_IDLE;
      approx_reg     <= 10'h000;
      trialMask_reg  <= 10'h000;
      activeCh_reg   <= 4'h0;
      resultBits_reg <= 10'h000;
      extPrev_reg    <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      // pin history for the external edge detector
      extPrev_reg  <= ext_trigger_pin;
      activeCh_reg <= activeCh_next;
      // msb trial loaded as the hold begins
      if (state_reg == ST_SAMPLE && stepPulse)
      begin
        trialMask_reg <= 10'h200;
        approx_reg    <= 10'h200;
      end
      // keep or drop the trial bit, then try the next lower one
      else if (state_reg == ST_CONV && stepPulse && !restartNow)
      begin
        trialMask_reg <= trialMask_reg >> 1;
        approx_reg    <= finalCode | (trialMask_reg >> 1);
        if (lastStep)
          resultBits_reg <= finalCode;
      end
    end
  end

  // analog outputs all registered
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      channelRoute <= 16'h0000;
      sampleHold   <= 1'b0;
      dacCode      <= 10'h000;
    end
    else
    begin
      channelRoute <= (state_next == ST_IDLE) ? 16'h0000 : chanOneHot(activeCh_next);
      sampleHold   <= (state_next == ST_CONV);
      dacCode      <= approx_reg;
    end
  end

  // digital port view masks the pin now routed to the converter
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      portIn_reg <= 16'h0000;
    else
      portIn_reg <= analogPinLevel & ~channelRoute;
  end

  // software registers; hardware set of done wins over write-one clear
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      conv_mode_reg      <= `SARSEQ_MODE_RST;
      channel_select_reg <= 4'h0;
      pf_mode_reg        <= 2'h0;
      pf_threshold_reg   <= 8'h00;
      status_reg         <= 2'h0;
      mask_reg           <= 2'h0;
      conv_done_irq      <= 1'b0;
    end
    else
    begin
      if (wrNow)
      begin
        case (wb_adr_i)
          `SARSEQ_OFF_MODE:   conv_mode_reg <= modeWrite;
          `SARSEQ_OFF_CHSEL:  if (wb_sel_i[0]) channel_select_reg <= wb_dat_i[3:0];
          `SARSEQ_OFF_PFMODE: if (wb_sel_i[0]) pf_mode_reg <= wb_dat_i[1:0];
          `SARSEQ_OFF_PFTHR:  if (wb_sel_i[0]) pf_threshold_reg <= wb_dat_i[7:0];
          `SARSEQ_OFF_MASK:   if (wb_sel_i[0]) mask_reg <= wb_dat_i[1:0];
          default:            mask_reg <= mask_reg;
        endcase
      end
      status_reg[`SARSEQ_ST_DONE] <= doneNext;
      status_reg[`SARSEQ_ST_BUSY] <= (state_next == ST_SAMPLE || state_next == ST_CONV);
      // busy is a state, not an event, so only done reaches the line
      conv_done_irq <= doneNext & mask_reg[`SARSEQ_ST_DONE];
    end
  end

  // read data registered, presented with ack
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wb_dat_o <= 32'h00000000;
    else if (accessNow && !wb_we_i)
    begin
      case (wb_adr_i)
        `SARSEQ_OFF_MODE:    wb_dat_o <= {21'h0, conv_mode_reg};
        `SARSEQ_OFF_CHSEL:   wb_dat_o <= {28'h0, channel_select_reg};
        `SARSEQ_OFF_PFMODE:  wb_dat_o <= {30'h0, pf_mode_reg};
        `SARSEQ_OFF_PFTHR:   wb_dat_o <= {24'h0, pf_threshold_reg};
        `SARSEQ_OFF_RESULT:  wb_dat_o <= {16'h0, leftResult};
        `SARSEQ_OFF_RESHIGH: wb_dat_o <= {24'h0, leftResult[15:8]};
        `SARSEQ_OFF_STATUS:  wb_dat_o <= {30'h0, status_reg};
        `SARSEQ_OFF_MASK:    wb_dat_o <= {30'h0, mask_reg};
        `SARSEQ_OFF_PORTIN:  wb_dat_o <= {16'h0, portIn_reg};
        // unmapped offsets read zero; the approximation register has none
        default:             wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule

// >>> sarseq_adc_ctrl_properties.sv
`timescale 1ns/1ns
`include "sarseq_regs.vh"
// watches the bus handshake, the front-end controls and the interrupt
module sarseq_adc_ctrl_props
(
  // clock and reset
  input wire        clk_sys,
  input wire        reset_n,
  // bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [5:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // front end and interrupt
  input wire [15:0] channelRoute,
  input wire        sampleHold,
  input wire [9:0]  dacCode,
  input wire        conv_done_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // read data is judged at the ack edge, while the master still holds the address
  wire rdAck = wb_ack_o && !wb_we_i;
  a_route_one_hot: assert property (channelRoute != 16'h0000 |-> $onehot(channelRoute))
    else $error("route not one-hot");
  a_hold_route_kept: assert property (sampleHold && $past(sampleHold) |-> $stable(channelRoute))
    else $error("route moved during hold");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_msb_first: assert property ($rose(sampleHold) |-> ##[0:8] dacCode == 10'h200)
    else $error("first trial not msb");
  a_irq_cause: assert property ($rose(conv_done_irq) |-> $past(sampleHold)
    || $past(sampleHold, 2) || $past(sampleHold, 3) || wb_ack_o || $past(wb_ack_o))
    else $error("irq without conversion end");
  a_result_low_zero: assert property (rdAck && wb_adr_i == `SARSEQ_OFF_RESULT
    |-> wb_dat_o[5:0] == 6'h00) else $error("result low bits set");
  a_high_byte_only: assert property (rdAck && wb_adr_i == `SARSEQ_OFF_RESHIGH
    |-> wb_dat_o[31:8] == 24'h000000) else $error("byte view too wide");
  a_sar_unmapped: assert property (rdAck && wb_adr_i == 6'h3C |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  // main scenarios reached
  c_irq: cover property ($rose(conv_done_irq));
  c_conv_end: cover property ($fell(sampleHold));
  c_result_read: cover property (rdAck && wb_adr_i == `SARSEQ_OFF_RESULT);
endmodule
bind sarseq_adc_ctrl sarseq_adc_ctrl_props sarseq_adc_ctrl_props_inst (.clk_sys, .reset_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .channelRoute,
  .sampleHold, .dacCode, .conv_done_irq);

// >>> sarseq_afe_model.sv
`timescale 1ns/1ns
// analog front end: follows the routed input until hold, then compares
module sarseq_afe_model
(
  // clock
  input wire         clk_sys,
  // ten-bit level per channel
  input wire [159:0] chanLevel,
  // controls from the sequencer
  input wire [15:0]  channelRoute,
  input wire         sampleHold,
  input wire [9:0]   dacCode,
  // comparator
  output wire        compBit
);
  reg [9:0] heldLevel = 10'h000;
  reg       wobble    = 1'b0;
  integer   i;
  // track while sampling; an ideal cap, so no droop during hold
  always @(posedge clk_sys)
  begin
    wobble <= ~wobble;
    if (!sampleHold)
      for (i = 0; i < 16; i = i + 1)
        if (channelRoute[i])
          heldLevel <= chanLevel[i*10 +: 10];
  end
  // outside hold the comparator output means nothing, so it toggles
  assign compBit = sampleHold ? (heldLevel >= dacCode) : wobble;
endmodule

// >>> sarseq_regs.vh
`ifndef SARSEQ_REGS_VH
`define SARSEQ_REGS_VH
// register word offsets (byte address, 32-bit aligned)
`define SARSEQ_OFF_MODE     6'h00
`define SARSEQ_OFF_CHSEL    6'h04
`define SARSEQ_OFF_PFMODE   6'h08
`define SARSEQ_OFF_PFTHR    6'h0C
`define SARSEQ_OFF_RESULT   6'h10
`define SARSEQ_OFF_RESHIGH  6'h14
`define SARSEQ_OFF_STATUS   6'h18
`define SARSEQ_OFF_MASK     6'h1C
`define SARSEQ_OFF_PORTIN   6'h20
// mode register fields
`define SARSEQ_MODE_EN      7
`define SARSEQ_MODE_SCAN    6
`define SARSEQ_MODE_HS_LO   4
`define SARSEQ_MODE_HS_HI   5
`define SARSEQ_MODE_FR_LO   1
`define SARSEQ_MODE_FR_HI   3
`define SARSEQ_MODE_TRG_LO  8
`define SARSEQ_MODE_TRG_HI  9
`define SARSEQ_MODE_EDGE    10
`define SARSEQ_MODE_W       11
// trigger source encodings
`define SARSEQ_TRG_SW       2'h0
`define SARSEQ_TRG_TIMER    2'h1
`define SARSEQ_TRG_EXT      2'h2
// power-fail mode fields
`define SARSEQ_PF_EN        1
`define SARSEQ_PF_BELOW     0
// status bits
`define SARSEQ_ST_DONE      0
`define SARSEQ_ST_BUSY      1
// widths and reset values
`define SARSEQ_RES_W        10
`define SARSEQ_CH_W         4
`define SARSEQ_MODE_RST     11'h000
`define SARSEQ_NCH          16
// clock cycles per bit step: base count scaled by frequency code
`define SARSEQ_STEP_BASE    8'h04
`endif

// >>> sarseq_step_timer.v
`timescale 1ns/1ns
// one-cycle enable pulse every (base << frCode) cycles, halved in high speed
module sarseq_step_timer
(
  // clock and reset
  input  wire       clk_sys,
  input  wire       reset_n,
  // control
  input  wire       run,
  input  wire [2:0] frCode,
  input  wire       highSpeed,
  // output
  output reg        stepPulse
);
`include "sarseq_regs.vh"
  reg  [10:0] count_reg;
  wire [10:0] period;

  // longer step for slower settling selections
  assign period = ({3'h0, `SARSEQ_STEP_BASE} << frCode) >> highSpeed;

  // counter restarts whenever the sequencer is idle
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_reg <= 11'h000;
      stepPulse <= 1'b0;
    end
    else if (!run)
    begin
      count_reg <= 11'h000;
      stepPulse <= 1'b0;
    end
    else if (count_reg + 11'h001 >= period)
    begin
      count_reg <= 11'h000;
      stepPulse <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 11'h001;
      stepPulse <= 1'b0;
    end
  end
endmodule

// >>> sarseq_wb_slave.v
`timescale 1ns/1ns
// classic wishbone handshake: ack one cycle after a new strobe, then dropped
module sarseq_wb_slave
(
  // clock and reset
  input  wire clk_sys,
  input  wire reset_n,
  // bus request
  input  wire wb_cyc_i,
  input  wire wb_stb_i,
  // handshake
  output reg  wb_ack_o,
  output wire accessNow
);
  // accessNow marks the single cycle in which a request is taken
  assign accessNow = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= accessNow;
  end
endmodule
